/* shared/wsts_pkg.sv */
package wsts_pkg;

    // Number of schedule timers.
    localparam int unsigned NUM_TIMERS = 4;
    // Minutes in one day, the width of time fields, the start time limits and the reset time.
    localparam int unsigned TIME_W = 11;
    localparam logic [10:0] MIN_PER_DAY = 11'h5a0;
    localparam logic [10:0] MAX_START_12H = 11'h59f;
    localparam logic [10:0] MAX_START_24H = 11'h5a0;
    localparam logic [10:0] TIME_RST = 11'h000;

    // Day selection codes.
    localparam logic [3:0] DAY_OFF = 4'h0;
    localparam logic [3:0] DAY_DAILY = 4'h1;
    localparam logic [3:0] DAY_WEEKDAYS = 4'h2;
    localparam logic [3:0] DAY_WEEKEND = 4'h3;
    localparam logic [3:0] DAY_MONDAY = 4'h4;
    localparam logic [3:0] DAY_SUNDAY = 4'ha;
    // Weekday numbering of the clock source, Monday first.
    localparam logic [2:0] WD_SATURDAY = 3'h5;
    localparam logic [2:0] WD_SUNDAY = 3'h6;

    // Action codes.
    localparam logic [1:0] ACT_OUTPUT_ONLY = 2'h0;
    localparam logic [1:0] ACT_RUN = 2'h1;
    localparam logic [1:0] ACT_RUN_NO_PI = 2'h2;
    localparam logic [1:0] ACT_ALTERNATE = 2'h3;

    // Reference source codes; code 6 is not a valid source.
    localparam logic [2:0] REF_PRESET_ONE = 3'h0;
    localparam logic [2:0] REF_TERMINALS = 3'h4;
    localparam logic [2:0] REF_SERIAL = 3'h5;
    localparam logic [2:0] REF_UNUSED = 3'h6;
    localparam logic [2:0] REF_PULSE = 3'h7;

    // Register map: each timer owns a block of eight words, five of them registers.
    localparam logic [7:0] TIMER_STRIDE = 8'h20;
    localparam logic [4:0] OFS_START = 5'h00;
    localparam logic [4:0] OFS_STOP = 5'h04;
    localparam logic [4:0] OFS_DAY = 5'h08;
    localparam logic [4:0] OFS_ACTION = 5'h0c;
    localparam logic [4:0] OFS_REF = 5'h10;
    localparam logic [7:0] ADDR_CONTROL = 8'h80;
    localparam logic [7:0] ADDR_STATUS = 8'h84;
    // Control register field positions and reset value.
    localparam int unsigned CTRL_FORMAT_BIT = 0;
    localparam int unsigned CTRL_LEGACY_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Configuration of one timer.
    typedef struct packed {
        logic [10:0] start_time;
        logic [10:0] stop_time;
        logic [3:0] day_select;
        logic [1:0] action_select;
        logic [2:0] reference_source;
    } wsts_cfg_t;

    // Current time and weekday from the clock source.
    typedef struct packed {
        logic [10:0] minute_of_day;
        logic [2:0] weekday;
        logic minute_tick;
    } wsts_now_t;

endpackage

/* design/wsts_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module wsts_timer (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Configuration and current time.
    input wire wsts_pkg::wsts_cfg_t cfg,
    input wire wsts_pkg::wsts_now_t now,
    input wire logic legacy_mode,
    // Activity of this timer.
    output logic active_q
);

    // True when the given weekday is one of the days the code selects.
    function automatic logic day_hit(input logic [3:0] code, input logic [2:0] wd);
        logic hit;
        hit = 1'b0;
        case (code)
            wsts_pkg::DAY_OFF: hit = 1'b0;
            wsts_pkg::DAY_DAILY: hit = 1'b1;
            wsts_pkg::DAY_WEEKDAYS: hit = (wd < wsts_pkg::WD_SATURDAY);
            wsts_pkg::DAY_WEEKEND: hit = (wd >= wsts_pkg::WD_SATURDAY) && (wd <= wsts_pkg::WD_SUNDAY);
            default: begin
                hit = (code >= wsts_pkg::DAY_MONDAY) && (code <= wsts_pkg::DAY_SUNDAY)
                    && (code == (wsts_pkg::DAY_MONDAY + {1'b0, wd}));
            end
        endcase
        return hit;
    endfunction

    // A setting of 24:00 matches the midnight that ends the day.
    function automatic logic time_hit(input logic [10:0] t, input logic [10:0] cur);
        return (cur == t) || ((t == wsts_pkg::MIN_PER_DAY) && (cur == wsts_pkg::TIME_RST));
    endfunction

    logic enabled; // Timer has a day code and is not vetoed by legacy mode.
    logic today; // Today is a selected day.
    logic single_day; // Exactly one weekday is selected.
    logic at_start; // Current minute equals the start time.
    logic at_stop; // Current minute equals the stop time.
    logic at_midnight; // Current minute is the start of a day.

    // Decode of the configuration against the current time.
    always_comb begin
        enabled = (cfg.day_select != wsts_pkg::DAY_OFF)
            && !(legacy_mode && (cfg.start_time > cfg.stop_time));
        today = day_hit(cfg.day_select, now.weekday);
        single_day = (cfg.day_select >= wsts_pkg::DAY_MONDAY);
        at_start = time_hit(cfg.start_time, now.minute_of_day);
        at_stop = time_hit(cfg.stop_time, now.minute_of_day);
        at_midnight = (now.minute_of_day == wsts_pkg::TIME_RST);
    end

    // Activity is set only on the minute tick of the clock source; a disabled timer clears at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
        end else if (!enabled) begin
            active_q <= 1'b0;
        end else if (now.minute_tick) begin
            if (cfg.start_time == cfg.stop_time) begin
                // Equal times: the start minute re-arms on every selected day.
                if (at_start) begin
                    active_q <= today;
                end else if (at_midnight && single_day && !today) begin
                    active_q <= 1'b0;
                end
            end else if (!active_q) begin
                // Starting needs the start minute on a selected day.
                if (at_start && today) begin
                    active_q <= 1'b1;
                end
            end else if (at_stop) begin
                // The stop may fall on the next day when the span crosses midnight.
                active_q <= 1'b0;
            end
        end
    end

endmodule // wsts_timer
`default_nettype wire

/* design/wsts_top.sv */
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wsts_top (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time from the clock source.
    input wire wsts_pkg::wsts_now_t now,
    // Per-timer status.
    output logic [3:0] timer_active,
    // Applied action.
    output logic digital_output_only,
    output logic run_request,
    output logic pi_disable,
    output logic alternation_permit,
    // Applied speed reference.
    output logic reference_valid,
    output logic [2:0] reference_select
);

    wsts_pkg::wsts_cfg_t cfg_q [wsts_pkg::NUM_TIMERS]; // Timer configurations.
    logic [1:0] ctrl_q; // Format and legacy mode bits.
    logic [3:0] active; // Activity from the timer units.
    logic apb_access; // Access phase of any transfer.
    logic [1:0] tsel; // Timer addressed by paddr.
    logic [4:0] tofs; // Offset within the timer block.
    logic in_timers; // Address falls in the timer blocks.
    logic mapped; // Address names a register.
    logic [10:0] start_max; // Highest start time for the current format.
    logic [1:0] winner; // Index of the governing timer.
    logic any_active; // Some timer is active.
    wsts_pkg::wsts_cfg_t wcfg; // Configuration of the governing timer.

    // Address decode; the bus never inserts wait states.
    always_comb begin
        apb_access = psel && penable;
        tsel = paddr[6:5];
        tofs = paddr[4:0];
        in_timers = (paddr[7] == 1'b0);
        mapped = 1'b0;
        if (in_timers) begin
            mapped = (tofs == wsts_pkg::OFS_START) || (tofs == wsts_pkg::OFS_STOP)
                || (tofs == wsts_pkg::OFS_DAY) || (tofs == wsts_pkg::OFS_ACTION)
                || (tofs == wsts_pkg::OFS_REF);
        end else begin
            mapped = (paddr == wsts_pkg::ADDR_CONTROL) || (paddr == wsts_pkg::ADDR_STATUS);
        end
        if (ctrl_q[wsts_pkg::CTRL_FORMAT_BIT]) begin
            start_max = wsts_pkg::MAX_START_24H;
        end else begin
            start_max = wsts_pkg::MAX_START_12H;
        end
    end

    assign pready = 1'b1;
    assign pslverr = apb_access && !mapped;

    // Timer configuration writes; an out-of-range start time is clamped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < wsts_pkg::NUM_TIMERS; i++) begin
                cfg_q[i].start_time <= wsts_pkg::TIME_RST;
                cfg_q[i].stop_time <= wsts_pkg::TIME_RST;
                cfg_q[i].day_select <= wsts_pkg::DAY_OFF;
                cfg_q[i].action_select <= wsts_pkg::ACT_OUTPUT_ONLY;
                cfg_q[i].reference_source <= wsts_pkg::REF_PRESET_ONE;
            end
        end else if (apb_access && pwrite && in_timers) begin
            case (tofs)
                wsts_pkg::OFS_START: begin
                    if (pwdata[10:0] > start_max) begin
                        cfg_q[tsel].start_time <= start_max;
                    end else begin
                        cfg_q[tsel].start_time <= pwdata[10:0];
                    end
                end
                wsts_pkg::OFS_STOP: cfg_q[tsel].stop_time <= pwdata[10:0];
                wsts_pkg::OFS_DAY: cfg_q[tsel].day_select <= pwdata[3:0];
                wsts_pkg::OFS_ACTION: cfg_q[tsel].action_select <= pwdata[1:0];
                wsts_pkg::OFS_REF: cfg_q[tsel].reference_source <= pwdata[2:0];
                default: begin
                    // Holes in the timer block take no write.
                end
            endcase
        end
    end

    // Control register write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= wsts_pkg::CTRL_RST;
        end else if (apb_access && pwrite && (paddr == wsts_pkg::ADDR_CONTROL)) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_access && !pwrite) begin
            if (in_timers) begin
                case (tofs)
                    wsts_pkg::OFS_START: prdata = {21'h0, cfg_q[tsel].start_time};
                    wsts_pkg::OFS_STOP: prdata = {21'h0, cfg_q[tsel].stop_time};
                    wsts_pkg::OFS_DAY: prdata = {28'h0, cfg_q[tsel].day_select};
                    wsts_pkg::OFS_ACTION: prdata = {30'h0, cfg_q[tsel].action_select};
                    wsts_pkg::OFS_REF: prdata = {29'h0, cfg_q[tsel].reference_source};
                    default: prdata = 32'h0000_0000;
                endcase
            end else if (paddr == wsts_pkg::ADDR_CONTROL) begin
                prdata = {30'h0, ctrl_q};
            end else if (paddr == wsts_pkg::ADDR_STATUS) begin
                prdata = {25'h0, any_active, winner, timer_active};
            end
        end
    end

    // One scheduling unit for each timer.
    for (genvar g = 0; g < wsts_pkg::NUM_TIMERS; g++) begin : g_timer
        wsts_timer u_timer (
            .pclk(pclk),
            .presetn(presetn),
            .cfg(cfg_q[g]),
            .now(now),
            .legacy_mode(ctrl_q[wsts_pkg::CTRL_LEGACY_BIT]),
            .active_q(active[g])
        );
    end

    // Priority: the lowest-numbered active timer governs.
    always_comb begin
        winner = 2'h0;
        any_active = |active;
        for (int i = wsts_pkg::NUM_TIMERS - 1; i >= 0; i--) begin
            if (active[i]) begin
                winner = 2'(i);
            end
        end
        wcfg = cfg_q[winner];
    end

    // Applied action and reference, registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_active <= 4'h0;
            digital_output_only <= 1'b0;
            run_request <= 1'b0;
            pi_disable <= 1'b0;
            alternation_permit <= 1'b0;
            reference_valid <= 1'b0;
            reference_select <= wsts_pkg::REF_PRESET_ONE;
        end else begin
            timer_active <= active;
            digital_output_only <= any_active
                && (wcfg.action_select == wsts_pkg::ACT_OUTPUT_ONLY);
            run_request <= any_active && ((wcfg.action_select == wsts_pkg::ACT_RUN)
                || (wcfg.action_select == wsts_pkg::ACT_RUN_NO_PI));
            pi_disable <= any_active && (wcfg.action_select == wsts_pkg::ACT_RUN_NO_PI);
            alternation_permit <= any_active && (wcfg.action_select == wsts_pkg::ACT_ALTERNATE)
                && (wcfg.day_select != wsts_pkg::DAY_OFF);
            if (any_active && ((wcfg.action_select == wsts_pkg::ACT_RUN)
                || (wcfg.action_select == wsts_pkg::ACT_RUN_NO_PI))
                && (wcfg.reference_source != wsts_pkg::REF_UNUSED)) begin
                reference_valid <= 1'b1;
                reference_select <= wcfg.reference_source;
            end else begin
                reference_valid <= 1'b0;
                reference_select <= wsts_pkg::REF_PRESET_ONE;
            end
        end
    end

endmodule // wsts_top
`default_nettype wire

/* testbench/wsts_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the ports of the scheduler top for bus and output relations.
module wsts_props (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Time and outputs.
    input wire wsts_pkg::wsts_now_t now,
    input wire logic [3:0] timer_active,
    input wire logic digital_output_only,
    input wire logic run_request,
    input wire logic pi_disable,
    input wire logic alternation_permit,
    input wire logic reference_valid,
    input wire logic [2:0] reference_select
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Recent ticks and writes; only these may move the activity flags.
    logic [1:0] tick_q;
    logic [3:0] wr_q;
    // Shift the history one place per cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 2'h0;
            wr_q <= 4'h0;
        end else begin
            tick_q <= {tick_q[0], now.minute_tick};
            wr_q <= {wr_q[2:0], psel & penable & pwrite};
        end
    end
    sequence s_acc; psel && penable; endsequence
    sequence s_hole; psel && penable && paddr == 8'h88; endsequence
    property p_ready; s_acc |-> pready; endproperty
    property p_hole; s_hole |-> pslverr && prdata == 32'h0; endproperty
    property p_quiet; !(psel && penable) |-> prdata == 32'h0 && !pslverr; endproperty
    property p_move; $changed(timer_active) |-> tick_q[1] || (|wr_q); endproperty
    property p_idle; timer_active == 4'h0 |-> !(alternation_permit || run_request); endproperty
    property p_noref;
        (digital_output_only || alternation_permit) |-> !reference_valid && reference_select == 3'h0;
    endproperty
    property p_ref6; reference_valid |-> reference_select != 3'h6 && run_request; endproperty
    property p_pi; pi_disable |-> run_request && !alternation_permit; endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    a_hole: assert property (p_hole) else $error("unmapped access not refused");
    a_quiet: assert property (p_quiet) else $error("bus outputs outside access");
    a_move: assert property (p_move) else $error("activity moved without tick");
    a_idle: assert property (p_idle) else $error("action with no timer active");
    a_noref: assert property (p_noref) else $error("reference on non-run action");
    a_ref6: assert property (p_ref6) else $error("invalid reference applied");
    a_pi: assert property (p_pi) else $error("bad action decode");
endmodule // wsts_props
`default_nettype wire

/* testbench/wsts_rtc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Clock source: shows a chosen minute and weekday with a one-cycle tick.
module wsts_rtc_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Command from the bench.
    input wire logic [10:0] set_min,
    input wire logic [2:0] set_wd,
    input wire logic go,
    // Time to the scheduler.
    output var wsts_pkg::wsts_now_t now
);
    // The fields change only together with a tick, as a real clock does.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            now <= '0;
        end else if (go) begin
            now <= '{set_min, set_wd, 1'b1};
        end else begin
            now.minute_tick <= 1'b0;
        end
    end
endmodule // wsts_rtc_model
`default_nettype wire

/* testbench/tb_weekly_sequence_timer_scheduler.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_weekly_sequence_timer_scheduler;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic go = 1'b0;
    logic obs = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [10:0] set_min = 11'h000;
    logic [2:0] set_wd = 3'h0;
    logic [31:0] prdata;
    logic pready, pslverr, digital_output_only, run_request, pi_disable;
    logic alternation_permit, reference_valid;
    logic [2:0] reference_select;
    logic [3:0] timer_active;
    wsts_pkg::wsts_now_t now;
    logic [31:0] exp_q[$]; // Expected results, oldest first.
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    logic [10:0] m;
    logic [2:0] w;
    always #10 pclk = ~pclk;
    wsts_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .now(now), .timer_active(timer_active),
        .digital_output_only(digital_output_only), .run_request(run_request),
        .pi_disable(pi_disable), .alternation_permit(alternation_permit),
        .reference_valid(reference_valid), .reference_select(reference_select));
    wsts_rtc_model i_rtc (.pclk(pclk), .presetn(presetn), .set_min(set_min), .set_wd(set_wd),
        .go(go), .now(now));
    // Prints the counts and the verdict, then stops.
    task finish_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task cmp(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    // Cuts a hang short.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    // Takes the oldest note whenever read data or an output snapshot appears.
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) cmp(prdata, exp_q.pop_front());
        if (obs) cmp({20'h0, reference_select, reference_valid, alternation_permit, pi_disable,
            run_request, digital_output_only, timer_active}, exp_q.pop_front());
    end
    // One APB transfer, held until ready is seen at a rising edge.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        apb(1'b0, a, 32'h0);
    endtask
    task cfg(input int n, input logic [4:0] o, input logic [31:0] d);
        apb(1'b1, 8'(n) * wsts_pkg::TIMER_STRIDE + {3'h0, o}, d);
    endtask
    // Sends one minute tick and lets the registered outputs settle.
    task tick(input logic [10:0] mm, input logic [2:0] ww);
        @(posedge pclk);
        set_min <= mm;
        set_wd <= ww;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task see(input logic [31:0] want);
        exp_q.push_back(want);
        // A config write moves the activity one edge later and the outputs one more.
        repeat (2) @(posedge pclk);
        obs <= 1'b1;
        @(posedge pclk);
        obs <= 1'b0;
    endtask
    // Output snapshot expected from the active set and the winner's codes.
    function automatic logic [31:0] ex(input logic [3:0] on, input logic [1:0] a,
        input logic [2:0] r);
        logic v;
        v = (a == 2'h1 || a == 2'h2) && r != 3'h6;
        if (on == 4'h0) return 32'h0;
        return {20'h0, v ? r : 3'h0, v, a == 2'h3, a == 2'h2, a == 2'h1 || a == 2'h2,
            a == 2'h0, on};
    endfunction
    // Whether a day code selects a weekday, Monday being zero.
    function automatic logic hit(input logic [3:0] d, input logic [2:0] wd);
        case (d)
            4'h0: return 1'b0;
            4'h1: return 1'b1;
            4'h2: return wd < 3'h5;
            4'h3: return wd >= 3'h5;
            default: return {1'b0, wd} == d - 4'h4;
        endcase
    endfunction
    // Main sequence.
    initial begin
        m = 11'($urandom(76));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 20; i++) rd(8'(i / 5 * 32 + i % 5 * 4), 32'h0);
        rd(8'h80, 32'h0);
        rd(8'h88, 32'h0);
        cfg(0, 5'h00, 32'h7ff);
        rd(8'h00, 32'h59f);
        apb(1'b1, 8'h80, 32'h1);
        cfg(0, 5'h00, 32'h7ff);
        rd(8'h00, 32'h5a0);
        apb(1'b1, 8'h80, 32'h0);
        m = 11'($urandom_range(1439));
        cfg(2, 5'h00, {21'h0, m});
        rd(8'h40, {21'h0, m});
        cfg(0, 5'h00, 32'h12c);
        cfg(0, 5'h04, 32'h384);
        cfg(0, 5'h0c, 32'h1);
        for (int d = 0; d < 11; d++) begin
            w = 3'($urandom_range(6));
            cfg(0, 5'h08, d);
            tick(11'h12c, w);
            see(ex({3'h0, hit(4'(d), w)}, 2'h1, 3'h0));
            tick(11'h384, w);
            see(32'h0);
        end
        // The day loop left a Sunday-only code; the action sweep ticks on a Monday.
        cfg(0, 5'h08, 32'h1);
        for (int i = 0; i < 16; i++) begin
            cfg(0, 5'h0c, i % 4);
            cfg(0, 5'h10, i / 2);
            tick(11'h12c, 3'h0);
            see(ex(4'h1, 2'(i % 4), 3'(i / 2)));
            tick(11'h384, 3'h0);
            see(32'h0);
        end
        cfg(0, 5'h0c, 32'h1);
        cfg(0, 5'h10, 32'h0);
        cfg(1, 5'h00, 32'h12c);
        cfg(1, 5'h04, 32'h384);
        cfg(1, 5'h08, 32'h1);
        cfg(1, 5'h0c, 32'h2);
        cfg(1, 5'h10, 32'h5);
        tick(11'h12c, 3'h0);
        see(ex(4'h3, 2'h1, 3'h0));
        rd(8'h84, 32'h43);
        cfg(0, 5'h08, 32'h0);
        see(ex(4'h2, 2'h2, 3'h5));
        tick(11'h384, 3'h0);
        cfg(1, 5'h08, 32'h0);
        cfg(0, 5'h00, 32'h514);
        cfg(0, 5'h04, 32'h064);
        cfg(0, 5'h08, 32'h1);
        tick(11'h514, 3'h2);
        see(ex(4'h1, 2'h1, 3'h0));
        tick(11'h000, 3'h3);
        see(ex(4'h1, 2'h1, 3'h0));
        tick(11'h064, 3'h3);
        see(32'h0);
        apb(1'b1, 8'h80, 32'h2);
        tick(11'h514, 3'h3);
        see(32'h0);
        apb(1'b1, 8'h80, 32'h0);
        cfg(0, 5'h00, 32'h258);
        cfg(0, 5'h04, 32'h258);
        tick(11'h258, 3'h0);
        tick(11'h258, 3'h1);
        see(ex(4'h1, 2'h1, 3'h0));
        cfg(0, 5'h08, 32'h4);
        tick(11'h000, 3'h1);
        see(32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0);
        finish_test();
    end
endmodule // tb_weekly_sequence_timer_scheduler
bind wsts_top wsts_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .now(now), .timer_active(timer_active),
    .digital_output_only(digital_output_only), .run_request(run_request),
    .pi_disable(pi_disable), .alternation_permit(alternation_permit),
    .reference_valid(reference_valid), .reference_select(reference_select));
`default_nettype wire
